/* logic/fmes_consts.vh */
// constants for the factory-mode erase sequencer
`ifndef FMES_CONSTS_VH
`define FMES_CONSTS_VH
`define FMES_OP_WR_EN 8'h06
`define FMES_OP_FM_ARM 8'h41
`define FMES_OP_BE64 8'hd8
`define FMES_OP_CE 8'h60
`define FMES_OP_CE_ALT 8'hc7
`define FMES_OP_RDSR 8'h05
`define FMES_T_SEL_DLY_US 800
`define FMES_CLK_MHZ 250
`define FMES_SEL_DLY_CYC (`FMES_T_SEL_DLY_US * `FMES_CLK_MHZ)
`define FMES_BLK_CYC 2000
`define FMES_BLK_FM_CYC 500
`define FMES_CE_CYC 8000
`define FMES_CE_FM_CYC 2000
`endif

/* logic/fmes_frame.v */
// serial frame receiver: collects bytes from the host link
`timescale 1ns/100ps
`include "fmes_consts.vh"

module fmes_frame (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // host link, sampled in clk domain
  input wire cs_b,
  input wire sclk,
  input wire si,
  // frame results
  output reg [7:0] op_q,
  output reg [5:0] bytes_q,
  output reg aligned_q,
  output reg end_q
);
  reg sclk_q;
  reg cs_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  wire rise = sclk & ~sclk_q & ~cs_b;

  // ------------------------------------------------------------
  // shift on sclk rise, flag end on cs rise
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
      bytes_q <= 6'h00;
      aligned_q <= 1'b1;
      end_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_b;
      end_q <= cs_b & ~cs_q; // one-cycle pulse at deselect
      if (!cs_b && cs_q) begin
        bit_q <= 3'h0;
        bytes_q <= 6'h00;
        aligned_q <= 1'b1;
      end else if (rise) begin
        sh_q <= {sh_q[6:0], si};
        bit_q <= bit_q + 3'h1;
        aligned_q <= (bit_q == 3'h7);
        if (bit_q == 3'h7) begin
          if (bytes_q == 6'h00)
            op_q <= {sh_q[6:0], si};
          if (bytes_q != 6'h3f)
            bytes_q <= bytes_q + 6'h01; // saturates; long frames stay long
        end
      end
    end
  end
endmodule

/* logic/fmes_top.v */
// factory-mode erase sequencer and power-on state logic
`timescale 1ns/100ps
`include "fmes_consts.vh"

// What this block does
// - armed flag then 64k block erase runs fast
// - flag clears at power-up, block erase done
// - armed flag then chip erase runs fast
// - flag clears when chip erase done
// - power-up lands in standby, not deep-down
// - write-enable latch cleared at power-up
// - below threshold, logic held, commands ignored
// - commands accepted after select delay
// - supply drop stops all operations
module fmes_top #(
  parameter SEL_DLY_CYC = `FMES_SEL_DLY_CYC,
  parameter BLK_CYC = `FMES_BLK_CYC,
  parameter BLK_FM_CYC = `FMES_BLK_FM_CYC,
  parameter CE_CYC = `FMES_CE_CYC,
  parameter CE_FM_CYC = `FMES_CE_FM_CYC
) (
  // clock and power-on reset
  input wire clk,
  input wire rst_b,
  // supply monitor, high while above write-inhibit threshold
  input wire supply_ok,
  // host serial link
  input wire cs_b,
  input wire sclk,
  input wire si,
  // device state
  output reg ready_q,
  output reg standby_q,
  output reg write_enable_latch_q,
  output reg factory_mode_q,
  output reg busy_q,
  // erase progress: kind and timing levels, end pulses
  output reg erase_block_q,
  output reg erase_chip_q,
  output reg erase_fast_q,
  output reg erase_done_q,
  output reg erase_abort_q
);
  // ------------------------------------------------------------
  // states, one-hot
  // ------------------------------------------------------------
  localparam [2:0] ST_WAIT = 3'b001;
  localparam [2:0] ST_IDLE = 3'b010;
  localparam [2:0] ST_ERASE = 3'b100;
  // the wait state doubles as the hold after power-on reset

  // ------------------------------------------------------------
  // frame results, delay and erase counters
  // ------------------------------------------------------------
  wire [7:0] op;
  wire [5:0] nbytes;
  wire aligned;
  wire frame_end;
  reg [2:0] st_q;
  // dly_q counts the power-up select delay, cnt_q the erase time
  reg [31:0] dly_q;
  reg [31:0] cnt_q;

  // chip erase has two opcodes
  // both codes take the same path and the same timing
  function is_ce;
    input [7:0] code;
    begin
      is_ce = (code == `FMES_OP_CE) || (code == `FMES_OP_CE_ALT);
    end
  endfunction

  // erase length pick, fast when the flag is armed
  function [31:0] erase_len;
    input chip;
    input fast;
    begin
      if (chip)
        erase_len = fast ? CE_FM_CYC : CE_CYC;
      else
        erase_len = fast ? BLK_FM_CYC : BLK_CYC;
    end
  endfunction

  // opcode and byte count of a finished frame both match
  function frame_is;
    input [7:0] code;
    input [5:0] len;
    input [7:0] want;
    input [5:0] want_len;
    begin
      frame_is = (code == want) && (len == want_len);
    end
  endfunction

  // ------------------------------------------------------------
  // frame receiver
  // ------------------------------------------------------------
  // all bit counting lives in the receiver; this side only decodes
  fmes_frame u_frame (
    .clk(clk),
    .rst_b(rst_b),
    .cs_b(cs_b),
    .sclk(sclk),
    .si(si),
    .op_q(op),
    .bytes_q(nbytes),
    .aligned_q(aligned),
    .end_q(frame_end)
  );

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  // a frame counts only on a byte boundary and while powered
  wire good = frame_end & aligned & supply_ok;
  wire is_wr_en = good & frame_is(op, nbytes, `FMES_OP_WR_EN, 6'h01);
  wire is_fm_arm = good & frame_is(op, nbytes, `FMES_OP_FM_ARM, 6'h01);
  wire is_blk = good & frame_is(op, nbytes, `FMES_OP_BE64, 6'h04);
  wire is_ce_f = good & is_ce(op) & (nbytes == 6'h01);

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // reset puts the part in standby, all clear
      st_q <= ST_WAIT;
      dly_q <= 32'h0;
      cnt_q <= 32'h0;
      // every output below is a flop, never a decode
      ready_q <= 1'b0;
      standby_q <= 1'b1;
      write_enable_latch_q <= 1'b0;
      factory_mode_q <= 1'b0;
      busy_q <= 1'b0;
      erase_block_q <= 1'b0;
      erase_chip_q <= 1'b0;
      erase_fast_q <= 1'b0;
      erase_done_q <= 1'b0;
      erase_abort_q <= 1'b0;
    end else begin
      // pulses default low; set below for a single cycle
      erase_done_q <= 1'b0;
      erase_abort_q <= 1'b0;
      if (!supply_ok) begin
        // supply drop: stop, drop volatile state, restart delay
        // cnt_q is left alone: nothing reads it outside the erase state
        if (busy_q)
          erase_abort_q <= 1'b1; // array contents may be corrupt
        st_q <= ST_WAIT;
        dly_q <= 32'h0;
        ready_q <= 1'b0;
        standby_q <= 1'b1;
        write_enable_latch_q <= 1'b0;
        factory_mode_q <= 1'b0;
        busy_q <= 1'b0;
        erase_block_q <= 1'b0;
        erase_chip_q <= 1'b0;
        erase_fast_q <= 1'b0;
      end else begin
        case (st_q)
          ST_WAIT: begin
            // commands ignored until select delay passes
            // the count restarts from zero after every supply drop
            if (dly_q >= SEL_DLY_CYC - 1) begin
              st_q <= ST_IDLE;
              ready_q <= 1'b1;
            end else begin
              dly_q <= dly_q + 32'h1;
            end
          end
          ST_IDLE: begin
            // only whole, powered frames get here, one per deselect
            if (is_wr_en) begin
              write_enable_latch_q <= 1'b1;
            end else if (is_fm_arm) begin
              // arming needs the latch; any other good frame except write enable or an accepted erase disarms
              factory_mode_q <= write_enable_latch_q;
            end else if ((is_blk || is_ce_f) && write_enable_latch_q) begin
              // the latch stays set until the erase ends
              st_q <= ST_ERASE;
              busy_q <= 1'b1;
              standby_q <= 1'b0;
              erase_block_q <= is_blk;
              erase_chip_q <= is_ce_f;
              erase_fast_q <= factory_mode_q;
              cnt_q <= erase_len(is_ce_f, factory_mode_q) - 32'h1;
            end else if (good) begin
              factory_mode_q <= 1'b0; // broken sequence cancels the arm
            end
          end
          ST_ERASE: begin
            // busy ignores new frames; status reads are not modelled here
            if (cnt_q == 32'h0) begin
              st_q <= ST_IDLE;
              busy_q <= 1'b0;
              standby_q <= 1'b1;
              erase_done_q <= 1'b1;
              write_enable_latch_q <= 1'b0;
              if (erase_block_q)
                factory_mode_q <= 1'b0;
              if (erase_chip_q)
                factory_mode_q <= 1'b0;
              erase_block_q <= 1'b0;
              erase_chip_q <= 1'b0;
              erase_fast_q <= 1'b0;
            end else begin
              cnt_q <= cnt_q - 32'h1;
            end
          end
          default: begin
            // stray code: fall back to the power-up wait, the safe side
            st_q <= ST_WAIT;
          end
        endcase
      end
    end
  end
endmodule

/* dv/fmes_host.sv */
// host link model: select, serial clock and data
`timescale 1ns/100ps
module fmes_host (
  // clock
  input wire clk,
  // serial link
  output logic cs_b,
  output logic sclk,
  output logic si
);
  // select idles high through power-up, clock stands low outside frames
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // whole bytes msb first
  task automatic send(input logic [31:0] d, input int nb);
    send_bits(d, 8 * nb);
  endtask
  // any bit count msb first; each phase held two cycles so the sampler sees it
  task automatic send_bits(input logic [31:0] d, input int nbits);
    @(negedge clk) cs_b = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      @(negedge clk) si = d[i];
      sclk = 1'b0;
      repeat (2) @(negedge clk);
      sclk = 1'b1;
      @(negedge clk);
    end
    @(negedge clk) sclk = 1'b0;
    @(negedge clk) cs_b = 1'b1;
    si = ~si;
    repeat (6) @(negedge clk);
  endtask
endmodule

/* dv/fmes_top_chk.sv */
// port checks for the factory-mode erase sequencer
`timescale 1ns/100ps
module fmes_top_chk (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // supply and state
  input wire supply_ok,
  input wire ready_q,
  input wire standby_q,
  input wire write_enable_latch_q,
  input wire factory_mode_q,
  input wire busy_q,
  input wire erase_block_q,
  input wire erase_chip_q,
  input wire erase_fast_q,
  input wire erase_done_q,
  input wire erase_abort_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  drop_clear_a: assert property (!supply_ok |=>
    !ready_q && !busy_q && !write_enable_latch_q)
    else $error("supply drop left state set");
  ready_hold_a: assert property ($fell(supply_ok) |=> !ready_q [*8])
    else $error("ready came back too soon");
  done_state_a: assert property (erase_done_q |->
    !busy_q && standby_q && !factory_mode_q)
    else $error("erase end left flag or busy set");
  done_pulse_a: assert property (erase_done_q |=> !erase_done_q)
    else $error("done pulse too long");
  busy_end_a: assert property ($fell(busy_q) |-> erase_done_q || erase_abort_q)
    else $error("busy dropped without done or abort");
  fast_arm_a: assert property ($rose(busy_q) |-> erase_fast_q == factory_mode_q)
    else $error("fast timing does not follow flag");
  kind_one_a: assert property (busy_q |-> erase_block_q != erase_chip_q)
    else $error("erase kind not unique");
  idle_gate_a: assert property (!ready_q |-> !busy_q && !write_enable_latch_q)
    else $error("command taken before ready");
endmodule
bind fmes_top fmes_top_chk u_chk (.clk, .rst_b, .supply_ok, .ready_q, .standby_q,
  .write_enable_latch_q, .factory_mode_q, .busy_q, .erase_block_q, .erase_chip_q,
  .erase_fast_q, .erase_done_q, .erase_abort_q);

/* dv/tb_fmes_top.sv */
// self-checking bench for the factory-mode erase sequencer
`timescale 1ns/100ps
module tb_fmes_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic supply_ok = 1'b1;
  wire cs_b, sclk, si, ready_q, standby_q, write_enable_latch_q, factory_mode_q, busy_q;
  wire erase_block_q, erase_chip_q, erase_fast_q, erase_done_q, erase_abort_q;
  int err_count = 0;
  int num_checks = 0;
  // short counts keep the run brief
  fmes_top #(.SEL_DLY_CYC(20), .BLK_CYC(20), .BLK_FM_CYC(5), .CE_CYC(40), .CE_FM_CYC(10)) dut (.*);
  fmes_host host (.clk, .cs_b, .sclk, .si);
  // 250 MHz clock
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic int exp_len(input logic chip, input logic fast);
    exp_len = chip ? (fast ? 10 : 40) : (fast ? 5 : 20);
  endfunction
  task automatic wait_ready();
    for (int n = 0; n < 100 && ready_q !== 1'b1; n++) @(negedge clk);
    chk(ready_q, 1'b1);
  endtask
  // erase time counted from select release: six cycles of send, then busy
  task automatic erase(input logic [31:0] d, input int nb, input logic chip, input logic fast);
    int n;
    n = 6;
    host.send(d, nb);
    chk({busy_q, erase_block_q, erase_chip_q}, {1'b1, ~chip, chip});
    chk({erase_fast_q, standby_q}, {fast, 1'b0});
    while (busy_q === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(n >= exp_len(chip, fast) + 2 && n <= exp_len(chip, fast) + 4, 1'b1);
    chk({write_enable_latch_q, factory_mode_q, standby_q}, 3'b001);
  endtask
  // main sequence: every erase kind slow and fast, then refusals and a drop
  initial begin
    logic [31:0] ops [3];
    int nb;
    void'($urandom(42));
    repeat (10) @(negedge clk);
    chk({ready_q, standby_q, write_enable_latch_q, factory_mode_q}, 4'b0100);
    rst_b = 1'b1;
    wait_ready();
    ops = '{32'hd8000000 | ($urandom & 32'hffffff), 32'h60, 32'hc7};
    for (int k = 0; k < 3; k++) begin
      for (int f = 0; f < 2; f++) begin
        host.send(32'h06, 1);
        chk(write_enable_latch_q, 1'b1);
        if (f == 1) host.send(32'h41, 1);
        chk(factory_mode_q, f[0]);
        erase(ops[k], k == 0 ? 4 : 1, k != 0, f[0]);
      end
    end
    // corners: erase and arm with the latch clear, long and ragged arm frames
    host.send(32'h60, 1);
    chk({busy_q, standby_q}, 2'b01);
    host.send(32'h41, 1);
    chk(factory_mode_q, 1'b0);
    host.send(32'h06, 1);
    host.send(32'h4100 | ($urandom & 32'hff), 2);
    chk(factory_mode_q, 1'b0);
    nb = 9 + ($urandom % 7);
    host.send_bits((32'h41 << (nb - 8)) | ($urandom & ((32'h1 << (nb - 8)) - 1)), nb);
    chk(factory_mode_q, 1'b0);
    // arm, then a second power-on reset must drop flag and latch
    host.send(32'h41, 1);
    chk(factory_mode_q, 1'b1);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    chk({ready_q, standby_q, write_enable_latch_q, factory_mode_q}, 4'b0100);
    rst_b = 1'b1;
    wait_ready();
    host.send(32'h06, 1);
    host.send(32'h41, 1);
    host.send(32'h60, 1);
    supply_ok = 1'b0;
    @(negedge clk);
    chk({busy_q, ready_q, write_enable_latch_q, factory_mode_q, erase_abort_q}, 5'h01);
    host.send(32'h06, 1);
    supply_ok = 1'b1;
    chk(write_enable_latch_q, 1'b0);
    wait_ready();
    finish_test();
  end
  // watchdog about seven times the expected span of the sequence
  initial begin
    #40000;
    err_count++;
    finish_test();
  end
endmodule
